// file: rtl/edm_params.svh
// constants for the energy detect / channel assessment measurement block
// assumes a 100 MHz system clock and an on-chip byte-wide register port
//
// Contract
// [R1] Clearing receive enable during a packet aborts and discards that packet.
// [R2] Hardware clears receive enable on TX streaming, sets it on RX streaming.
// [R3] Backoff assessment and ack wait turn the radio to receive regardless.
// [R4] Host changes receive settings only while receive enable is cleared.
// [R5] Parsing disable set means only CRC check, no frame parsing.
// [R6] Security start begins processing, reads 1 while busy, self-clears on done; a start in the sec_done cycle keeps the bit but sends no o_sec_start.
// [R7] Link quality append set adds link quality after the received frame.
// [R8] Signal strength append set adds signal strength to receive status vector.
// [R9] Busy flag holds latest assessment result, hardware-only set and clear.
// [R10] Assessment start launches assessment, cleared on completion with done flag raised.
// [R11] Energy modes: busy when mean upper six bits exceed threshold.
// [R12] Threshold used only in energy modes, 2 dB per step, resets 001100.
// [R13] Host-started assessment needs receive enabled; reception stays active meanwhile.
// [R14] Sampling mode does one 128 us peak measurement into peak result.
// [R15] Scan mode: length field sets duration, mean goes to mean result.
// [R16] Energy start begins measurement, cleared when results valid, done flag untouched.
// [R17] Receive state change or host clearing start aborts energy measurement.
// [R18] Length M gives (M+1)*8 atoms of 128 us; field resets 1110.
// [R19] Energy measurement needs receive enabled and suspends packet reception.
// [R20] Signal strength averaged per 128 us atom; largest atom kept as peak.
// [R21] Mean result holds measured mean, resets to zero.
// [R22] Mean code maps to power at 0.5 dB per step minus 112 dBm.
// [R23] Start writes while a measurement runs are ignored until it ends.
`ifndef EDM_PARAMS_SVH
`define EDM_PARAMS_SVH

`define EDM_CLK_NS            10
`define EDM_ATOM_US           128
`define EDM_ATOM_CYCLES       ((`EDM_ATOM_US * 1000) / `EDM_CLK_NS)
`define EDM_ATOM_SAMPLES      128
`define EDM_ATOM_SHIFT        7
`define EDM_SCAN_SHIFT        3
`define EDM_CCA_UNIT_US       32
`define EDM_CCA_UNIT_SAMPLES  ((`EDM_CCA_UNIT_US * `EDM_ATOM_SAMPLES) / `EDM_ATOM_US)
`define EDM_CCA_UNIT_SHIFT    5

`define EDM_ADDR_CCA_CTL      8'h2F
`define EDM_ADDR_RX_CTL       8'h30
`define EDM_ADDR_ED_CTL       8'h31
`define EDM_ADDR_MEAN         8'h32
`define EDM_ADDR_PEAK         8'h33

`define EDM_RX_EN_BIT         7
`define EDM_RX_NOPARSE_BIT    6
`define EDM_RX_SEC_BIT        5
`define EDM_RX_LQI_BIT        4
`define EDM_RX_RSSI_BIT       3
`define EDM_CCA_BUSY_BIT      7
`define EDM_CCA_START_BIT     6
`define EDM_ED_MODE_BIT       5
`define EDM_ED_START_BIT      4

`define EDM_THR_RESET         6'h0C
`define EDM_LEN_RESET         4'hE
`define EDM_MEAN_RESET        8'h00
`define EDM_PEAK_RESET        8'h00
`define EDM_THR_DB_PER_STEP   2
`define EDM_MEAN_TENTH_DB     5
`define EDM_MEAN_OFFSET_DBM   112
`define EDM_MEAN_CODE_MIN     40
`define EDM_MEAN_CODE_MAX     184

`endif

// file: rtl/edm_pkg.sv
// types shared by the energy detect / channel assessment block
// assumes edm_params.svh supplies every numeric constant
package edm_pkg;

    typedef enum logic [1:0] {
        EDM_IDLE = 2'b00,
        EDM_ED   = 2'b01,
        EDM_CCA  = 2'b10
    } edm_state_e;

    typedef enum logic [1:0] {
        EDM_TRX_PACKET    = 2'b00,
        EDM_TRX_TX_STREAM = 2'b01,
        EDM_TRX_RX_STREAM = 2'b10
    } edm_trx_e;

    typedef enum logic [1:0] {
        EDM_CCA_ED_OR_CS  = 2'b00,
        EDM_CCA_ED        = 2'b01,
        EDM_CCA_CS        = 2'b10,
        EDM_CCA_ED_AND_CS = 2'b11
    } edm_cca_mode_e;

    typedef struct packed {
        logic frame_active;
        logic state_chg;
        logic carrier_sense;
        logic sec_done;
        logic backoff_cca;
        logic ack_wait;
    } edm_radio_s;

    typedef struct packed {
        logic rx_gate;
        logic parse_bypass;
        logic append_lqi;
        logic append_rssi;
        logic radio_rx_on;
        logic rx_suspend;
    } edm_rx_ctl_s;

endpackage

// file: rtl/edm_top.sv
// energy detect, channel assessment and receive control registers
// assumes radio status inputs and rssi samples are already on i_clk_sys
`timescale 1ns/1ps
`include "edm_params.svh"

module edm_top #(
    parameter int P_ATOM_CYCLES = `EDM_ATOM_CYCLES
) (
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    // register port
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    output logic      [7:0]            o_reg_rdata,
    // radio side
    input  wire logic [1:0]            i_trx_mode,
    input  wire logic [1:0]            i_cca_mode,
    input  wire logic [1:0]            i_cca_len,
    input  wire logic [7:0]            i_rssi,
    input  wire edm_pkg::edm_radio_s   i_radio,
    // control to receiver
    output edm_pkg::edm_rx_ctl_s       o_rx_ctl,
    output logic                       o_rx_abort,
    output logic                       o_sec_start,
    output logic                       o_assess_done
);

    // one rssi sample per tick, 128 ticks per atom
    localparam int TICK = (P_ATOM_CYCLES / `EDM_ATOM_SAMPLES) < 1 ? 1 : (P_ATOM_CYCLES / `EDM_ATOM_SAMPLES);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // control and status registers
    logic                  receive_enable_ctl_reg;
    logic                  receive_enable_ctl_next;
    logic                  noparse_reg;
    logic                  sec_reg;
    logic                  lqi_reg;
    logic                  rssi_en_reg;
    logic                  busy_reg;
    logic                  cca_st_reg;
    logic [5:0]            thr_reg;
    logic                  energy_mode_select_reg;
    logic                  energy_measure_start_reg;
    logic [3:0]            energy_measure_length_reg;
    logic [7:0]            mean_reg;
    logic [7:0]            peak_reg;
    logic [1:0]            trx_prev_reg;

    // measurement engine
    edm_pkg::edm_state_e   state_reg;
    logic [15:0]           tick_cnt_reg;
    logic [8:0]            samp_cnt_reg;
    logic [7:0]            atom_cnt_reg;
    logic [15:0]           acc_reg;
    logic [15:0]           seq_sum_reg;
    logic [7:0]            seq_peak_reg;
    logic                  cs_seen_reg;

    logic                  wr_rx;
    logic                  wr_cca;
    logic                  wr_ed;
    logic                  wr_mean;
    logic                  tick;
    logic                  ed_start;
    logic                  cca_start;
    logic                  ed_abort;
    logic                  atom_end;
    logic                  ed_fin;
    logic                  cca_fin;
    logic [15:0]           acc_sum;
    logic [7:0]            atom_avg;
    logic [7:0]            atoms_total;
    logic [15:0]           seq_total;
    logic [7:0]            seq_peak_new;
    logic [7:0]            ed_mean;
    logic [8:0]            cca_samples;
    logic [7:0]            cca_mean;
    logic                  energy_hi;
    logic                  cca_busy;
    logic [7:0]            rd_data;

    always_comb begin
        wr_rx   = i_reg_wr && hit(i_reg_addr, `EDM_ADDR_RX_CTL);
        wr_cca  = i_reg_wr && hit(i_reg_addr, `EDM_ADDR_CCA_CTL);
        wr_ed   = i_reg_wr && hit(i_reg_addr, `EDM_ADDR_ED_CTL);
        wr_mean = i_reg_wr && hit(i_reg_addr, `EDM_ADDR_MEAN);
        tick    = (tick_cnt_reg == 16'(TICK - 1));
        // starts only from idle, so a repeated 1 is dropped while busy
        ed_start  = (state_reg == edm_pkg::EDM_IDLE) && wr_ed && i_reg_wdata[`EDM_ED_START_BIT]; // [R16] [R23]
        cca_start = (state_reg == edm_pkg::EDM_IDLE) && wr_cca && i_reg_wdata[`EDM_CCA_START_BIT]
                    && !ed_start; // [R10] [R23]
        ed_abort  = (state_reg == edm_pkg::EDM_ED)
                    && (i_radio.state_chg || (wr_ed && !i_reg_wdata[`EDM_ED_START_BIT])); // [R17]
    end

    // energy scan arithmetic
    always_comb begin
        acc_sum      = acc_reg + {8'h00, i_rssi};
        atom_avg     = acc_sum[`EDM_ATOM_SHIFT +: 8]; // [R20]
        atoms_total  = energy_mode_select_reg ? 8'h01 : 8'(({4'h0, energy_measure_length_reg} + 8'h01) << `EDM_SCAN_SHIFT); // [R14] [R18]
        atom_end     = (state_reg == edm_pkg::EDM_ED) && tick
                       && (samp_cnt_reg == 9'(`EDM_ATOM_SAMPLES - 1));
        ed_fin       = atom_end && (atom_cnt_reg == atoms_total - 8'h01) && !ed_abort;
        seq_total    = seq_sum_reg + {8'h00, atom_avg};
        seq_peak_new = (atom_avg > seq_peak_reg) ? atom_avg : seq_peak_reg; // [R20]
        ed_mean      = 8'(seq_total / {8'h00, atoms_total}); // [R15]
    end

    // assessment window of 32 us << length, mean by shift
    always_comb begin
        cca_samples = 9'(`EDM_CCA_UNIT_SAMPLES) << i_cca_len;
        cca_fin     = (state_reg == edm_pkg::EDM_CCA) && tick && (samp_cnt_reg == cca_samples - 9'h001);
        cca_mean    = 8'(acc_sum >> (`EDM_CCA_UNIT_SHIFT + i_cca_len));
        energy_hi   = cca_mean[7:2] > thr_reg; // [R11]
        case (edm_pkg::edm_cca_mode_e'(i_cca_mode))
            edm_pkg::EDM_CCA_ED:        cca_busy = energy_hi; // [R12]
            edm_pkg::EDM_CCA_CS:        cca_busy = cs_seen_reg || i_radio.carrier_sense;
            edm_pkg::EDM_CCA_ED_AND_CS: cca_busy = energy_hi && (cs_seen_reg || i_radio.carrier_sense); // [R12]
            default:                    cca_busy = energy_hi || cs_seen_reg || i_radio.carrier_sense;
        endcase
    end

    // receive enable: host write, then hardware mode switch overrides
    always_comb begin
        receive_enable_ctl_next = receive_enable_ctl_reg;
        if (wr_rx) begin
            receive_enable_ctl_next = i_reg_wdata[`EDM_RX_EN_BIT];
        end
        if (i_trx_mode != trx_prev_reg) begin
            if (i_trx_mode == edm_pkg::EDM_TRX_TX_STREAM) begin
                receive_enable_ctl_next = 1'b0; // [R2]
            end else if (i_trx_mode == edm_pkg::EDM_TRX_RX_STREAM) begin
                receive_enable_ctl_next = 1'b1; // [R2]
            end
        end
    end

    // receive control register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            receive_enable_ctl_reg     <= 1'b0;
            noparse_reg  <= 1'b0;
            sec_reg      <= 1'b0;
            lqi_reg      <= 1'b0;
            rssi_en_reg  <= 1'b0;
            trx_prev_reg <= 2'h0;
        end else begin
            receive_enable_ctl_reg     <= receive_enable_ctl_next;
            trx_prev_reg <= i_trx_mode;
            if (wr_rx) begin
                noparse_reg <= i_reg_wdata[`EDM_RX_NOPARSE_BIT]; // [R5]
                lqi_reg     <= i_reg_wdata[`EDM_RX_LQI_BIT]; // [R7]
                rssi_en_reg <= i_reg_wdata[`EDM_RX_RSSI_BIT]; // [R8]
            end
            // a new start in the done cycle wins over the self-clear
            if (wr_rx && i_reg_wdata[`EDM_RX_SEC_BIT]) begin
                sec_reg <= 1'b1; // [R6]
            end else if (i_radio.sec_done) begin
                sec_reg <= 1'b0; // [R6]
            end
        end
    end

    // assessment control register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_reg   <= 1'b0;
            cca_st_reg <= 1'b0;
            thr_reg    <= `EDM_THR_RESET;
        end else begin
            if (wr_cca) begin
                thr_reg <= i_reg_wdata[5:0]; // [R12]
            end
            if (cca_start) begin
                cca_st_reg <= 1'b1; // [R10]
            end else if (cca_fin) begin
                cca_st_reg <= 1'b0; // [R10]
            end
            if (cca_fin) begin
                busy_reg <= cca_busy; // [R9]
            end
        end
    end

    // energy detect control register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            energy_mode_select_reg <= 1'b0;
            energy_measure_start_reg   <= 1'b0;
            energy_measure_length_reg  <= `EDM_LEN_RESET;
        end else begin
            if (wr_ed) begin
                energy_mode_select_reg <= i_reg_wdata[`EDM_ED_MODE_BIT];
                energy_measure_length_reg  <= i_reg_wdata[3:0]; // [R18]
            end
            if (ed_start) begin
                energy_measure_start_reg <= 1'b1; // [R16]
            end else if (ed_fin || ed_abort) begin
                energy_measure_start_reg <= 1'b0; // [R16] [R17]
            end
        end
    end

    // measurement sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg    <= edm_pkg::EDM_IDLE;
            tick_cnt_reg <= 16'h0000;
            samp_cnt_reg <= 9'h000;
            atom_cnt_reg <= 8'h00;
            acc_reg      <= 16'h0000;
            seq_sum_reg  <= 16'h0000;
            seq_peak_reg <= 8'h00;
            cs_seen_reg  <= 1'b0;
        end else begin
            tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
            if (ed_start || cca_start) begin
                state_reg    <= ed_start ? edm_pkg::EDM_ED : edm_pkg::EDM_CCA;
                tick_cnt_reg <= 16'h0000;
                samp_cnt_reg <= 9'h000;
                atom_cnt_reg <= 8'h00;
                acc_reg      <= 16'h0000;
                seq_sum_reg  <= 16'h0000;
                seq_peak_reg <= 8'h00;
                cs_seen_reg  <= 1'b0;
            end else if (ed_abort || ed_fin || cca_fin) begin
                state_reg <= edm_pkg::EDM_IDLE; // [R17]
            end else if (state_reg == edm_pkg::EDM_CCA) begin
                cs_seen_reg <= cs_seen_reg || i_radio.carrier_sense;
                if (tick) begin
                    acc_reg      <= acc_sum;
                    samp_cnt_reg <= samp_cnt_reg + 9'h001;
                end
            end else if (atom_end) begin
                acc_reg      <= 16'h0000; // [R18]
                samp_cnt_reg <= 9'h000;
                atom_cnt_reg <= atom_cnt_reg + 8'h01;
                seq_sum_reg  <= seq_total;
                seq_peak_reg <= seq_peak_new;
            end else if ((state_reg == edm_pkg::EDM_ED) && tick) begin
                acc_reg      <= acc_sum;
                samp_cnt_reg <= samp_cnt_reg + 9'h001;
            end
        end
    end

    // result registers; mean code reads as 0.5 dB steps above -112 dBm
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mean_reg <= `EDM_MEAN_RESET; // [R21]
            peak_reg <= `EDM_PEAK_RESET;
        end else begin
            if (ed_fin) begin
                mean_reg <= ed_mean; // [R15] [R21] [R22]
                peak_reg <= seq_peak_new; // [R14] [R20]
            end else if (cca_fin && (i_cca_mode != edm_pkg::EDM_CCA_CS)) begin
                mean_reg <= cca_mean; // [R21]
            end else if (wr_mean) begin
                mean_reg <= i_reg_wdata;
            end
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (hit(i_reg_addr, `EDM_ADDR_RX_CTL)) begin
            rd_data = {receive_enable_ctl_reg, noparse_reg, sec_reg, lqi_reg, rssi_en_reg, 3'h0};
        end else if (hit(i_reg_addr, `EDM_ADDR_CCA_CTL)) begin
            rd_data = {busy_reg, cca_st_reg, thr_reg};
        end else if (hit(i_reg_addr, `EDM_ADDR_ED_CTL)) begin
            rd_data = {2'h0, energy_mode_select_reg, energy_measure_start_reg, energy_measure_length_reg};
        end else if (hit(i_reg_addr, `EDM_ADDR_MEAN)) begin
            rd_data = mean_reg;
        end else if (hit(i_reg_addr, `EDM_ADDR_PEAK)) begin
            rd_data = peak_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_data;
        end
    end

    // receiver controls; host must keep receive enabled for its own measurements
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_ctl      <= '0;
            o_rx_abort    <= 1'b0;
            o_sec_start   <= 1'b0;
            o_assess_done <= 1'b0;
        end else begin
            // energy scan holds reception off, assessment leaves it running
            o_rx_ctl.rx_gate      <= receive_enable_ctl_next && (state_reg != edm_pkg::EDM_ED) && !ed_start; // [R1] [R13] [R19]
            o_rx_ctl.rx_suspend   <= (state_reg == edm_pkg::EDM_ED) || ed_start; // [R19]
            o_rx_ctl.parse_bypass <= noparse_reg; // [R5]
            o_rx_ctl.append_lqi   <= lqi_reg; // [R7]
            o_rx_ctl.append_rssi  <= rssi_en_reg; // [R8]
            o_rx_ctl.radio_rx_on  <= receive_enable_ctl_reg || i_radio.backoff_cca || i_radio.ack_wait
                                     || (state_reg != edm_pkg::EDM_IDLE) || ed_start || cca_start; // [R3]
            o_rx_abort            <= receive_enable_ctl_reg && !receive_enable_ctl_next && i_radio.frame_active; // [R1]
            o_sec_start           <= wr_rx && i_reg_wdata[`EDM_RX_SEC_BIT] && !sec_reg; // [R6]
            o_assess_done         <= cca_fin; // [R10]
        end
    end

endmodule

// file: dv/edm_top_asserts.sv
// port assertions for the measurement block
// assumes one clock domain and binding into edm_top
`timescale 1ns/1ps
module edm_top_asserts #(
    parameter int P_ATOM_CYCLES = 256
) (
    // watched ports
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst_n,
    input wire logic                 i_reg_wr,
    input wire logic [7:0]           i_reg_addr,
    input wire logic [7:0]           i_reg_wdata,
    input wire logic [1:0]           i_trx_mode,
    input wire edm_pkg::edm_radio_s  i_radio,
    input wire edm_pkg::edm_rx_ctl_s o_rx_ctl,
    input wire logic                 o_rx_abort,
    input wire logic                 o_sec_start,
    input wire logic                 o_assess_done
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic rx_wr;
    assign rx_wr = i_reg_wr && (i_reg_addr == 8'h30);
    chk_abort_cause: assert property (o_rx_abort |-> $past(i_radio.frame_active))
        else $error("abort without frame");
    chk_abort_pulse: assert property (o_rx_abort |=> !o_rx_abort)
        else $error("abort too long");
    chk_tx_stream_off: assert property ((i_trx_mode == 2'h1 && $changed(i_trx_mode)) |->
        ##[1:2] !o_rx_ctl.rx_gate)
        else $error("tx stream left rx on");
    chk_rx_stream_on: assert property ((i_trx_mode == 2'h2 && $changed(i_trx_mode)) |->
        ##[1:2] (o_rx_ctl.rx_gate || o_rx_ctl.rx_suspend))
        else $error("rx stream left rx off");
    chk_radio_forced: assert property ((i_radio.backoff_cca || i_radio.ack_wait) |->
        ##[0:2] o_rx_ctl.radio_rx_on)
        else $error("radio not in receive");
    chk_parse_follow: assert property (rx_wr |-> ##2 (o_rx_ctl.parse_bypass == $past(i_reg_wdata[6], 2)))
        else $error("bypass mismatch");
    chk_lqi_follow: assert property (rx_wr |-> ##2 (o_rx_ctl.append_lqi == $past(i_reg_wdata[4], 2)))
        else $error("lqi append mismatch");
    chk_rssi_follow: assert property (rx_wr |-> ##2 (o_rx_ctl.append_rssi == $past(i_reg_wdata[3], 2)))
        else $error("rssi append mismatch");
    chk_sec_cause: assert property (o_sec_start |-> $past(rx_wr && i_reg_wdata[5]))
        else $error("kick without write");
    chk_sec_pulse: assert property (o_sec_start |=> !o_sec_start)
        else $error("kick too long");
    chk_done_pulse: assert property (o_assess_done |=> !o_assess_done)
        else $error("done too long");
    chk_suspend_gate: assert property (o_rx_ctl.rx_suspend |-> !o_rx_ctl.rx_gate && o_rx_ctl.radio_rx_on)
        else $error("rx not suspended");
    cover property (o_rx_abort);
    cover property (o_sec_start);
    cover property (o_assess_done);
    cover property (o_rx_ctl.rx_suspend);
endmodule

bind edm_top edm_top_asserts #(.P_ATOM_CYCLES(P_ATOM_CYCLES)) u_asserts (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_trx_mode(i_trx_mode), .i_radio(i_radio), .o_rx_ctl(o_rx_ctl),
    .o_rx_abort(o_rx_abort), .o_sec_start(o_sec_start), .o_assess_done(o_assess_done));

// file: dv/edm_host_model.sv
// host side of the register port: byte writes and reads, one strobe cycle each
// assumes strobes taken on the rising edge and read data one edge later
`timescale 1ns/1ps
module edm_host_model (
    // clock
    input  wire logic       i_clk_sys,
    // register port
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    input  wire logic [7:0] i_rdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hFF;
        o_wdata = 8'hFF;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        #1;
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = v;
        @(posedge i_clk_sys);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~v;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        #1;
        o_rd = 1'b1;
        o_addr = a;
        @(posedge i_clk_sys);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        v = i_rdata;
    endtask
endmodule

// file: dv/energy_detect_cca_measure_test.sv
// self-checking bench for the measurement block
// assumes a shortened atom of 256 cycles and the host model on the register port
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module energy_detect_cca_measure_test;
    logic                 clk, rst_n, wr, rd, rx_abort, sec_start, assess_done;
    logic [7:0]           addr, wdata, rdata, rssi, d;
    logic [1:0]           trx_mode, cca_mode, cca_len;
    edm_pkg::edm_radio_s  radio;
    edm_pkg::edm_rx_ctl_s rx_ctl;
    int                   err_count, comparisons, n, n_abort, n_sec, n_done;

    edm_host_model u_host (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));
    edm_top #(.P_ATOM_CYCLES(256)) u_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_trx_mode(trx_mode), .i_cca_mode(cca_mode),
        .i_cca_len(cca_len), .i_rssi(rssi), .i_radio(radio), .o_rx_ctl(rx_ctl),
        .o_rx_abort(rx_abort), .o_sec_start(sec_start), .o_assess_done(assess_done));

    // pulses are counted so a scenario can judge them after they pass
    always @(posedge clk) begin
        if (rx_abort === 1'b1) n_abort++;
        if (sec_start === 1'b1) n_sec++;
        if (assess_done === 1'b1) n_done++;
    end
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_clr(input logic [7:0] a, input logic [7:0] m, input int lim);
        for (int i = 0; i < lim; i++) begin
            u_host.rd_reg(a, d);
            if ((d & m) === 8'h00) break;
        end
    endtask
    task automatic t_reset;
        logic [7:0] ad [6] = '{8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40};
        logic [7:0] ex [6] = '{8'h0C, 8'h00, 8'h0E, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            u_host.rd_reg(ad[i], d);
            `CHK(d, ex[i])
        end
    endtask
    task automatic t_access;
        u_host.wr_reg(8'h33, 8'hFF);
        u_host.rd_reg(8'h33, d);
        `CHK(d, 8'h00)
        u_host.wr_reg(8'h32, 8'h5A);
        u_host.rd_reg(8'h32, d);
        `CHK(d, 8'h5A)
        u_host.wr_reg(8'h2F, 8'hBF);
        u_host.rd_reg(8'h2F, d);
        `CHK(d, 8'h3F)
        u_host.wr_reg(8'h2F, 8'h0C);
        u_host.wr_reg(8'h31, 8'hCE);
        u_host.rd_reg(8'h31, d);
        `CHK(d, 8'h0E)
    endtask
    task automatic t_rxctl;
        u_host.wr_reg(8'h30, 8'h58);
        u_host.wr_reg(8'h30, 8'hD8);
        repeat (2) step;
        `CHK(rx_ctl[5:2], 4'hF)
        u_host.wr_reg(8'h30, 8'h58);
        u_host.wr_reg(8'h30, 8'h18);
        repeat (2) step;
        `CHK(rx_ctl.parse_bypass, 1'b0)
        trx_mode = 2'h2;
        u_host.rd_reg(8'h30, d);
        `CHK(d[7], 1'b1)
        trx_mode = 2'h1;
        u_host.rd_reg(8'h30, d);
        `CHK(d[7], 1'b0)
        trx_mode = 2'h0;
        u_host.wr_reg(8'h30, 8'h00);
        radio.backoff_cca = 1'b1;
        repeat (3) step;
        `CHK(rx_ctl.radio_rx_on, 1'b1)
        radio.backoff_cca = 1'b0;
        radio.ack_wait = 1'b1;
        repeat (3) step;
        `CHK(rx_ctl.radio_rx_on, 1'b1)
        radio.ack_wait = 1'b0;
        `CHK(n_abort, 0)
        u_host.wr_reg(8'h30, 8'h80);
        radio.frame_active = 1'b1;
        u_host.wr_reg(8'h30, 8'h00);
        repeat (3) step;
        `CHK(n_abort, 1)
        radio.frame_active = 1'b0;
    endtask
    task automatic t_security;
        n = n_sec;
        u_host.wr_reg(8'h30, 8'h20);
        u_host.rd_reg(8'h30, d);
        `CHK(d[5], 1'b1)
        `CHK(n_sec - n, 1)
        radio.sec_done = 1'b1;
        step;
        radio.sec_done = 1'b0;
        u_host.rd_reg(8'h30, d);
        `CHK(d[5], 1'b0)
    endtask
    task automatic t_sampling;
        u_host.wr_reg(8'h30, 8'h80);
        rssi = 8'h40;
        n = n_done;
        u_host.wr_reg(8'h31, 8'h30);
        repeat (4) step;
        `CHK(rx_ctl.rx_suspend, 1'b1)
        u_host.wr_reg(8'h2F, 8'h4C);
        u_host.rd_reg(8'h2F, d);
        `CHK(d[6], 1'b0)
        wait_clr(8'h31, 8'h10, 300);
        `CHK(d[4], 1'b0)
        u_host.rd_reg(8'h33, d);
        `CHK(d, 8'h40)
        u_host.rd_reg(8'h32, d);
        `CHK(d, 8'h40)
        `CHK(n_done - n, 0)
        `CHK(rx_ctl.rx_suspend, 1'b0)
    endtask
    task automatic t_scan;
        rssi = 8'h20;
        u_host.wr_reg(8'h31, 8'h10);
        repeat (1500) step;
        u_host.rd_reg(8'h31, d);
        `CHK(d[4], 1'b1)
        wait_clr(8'h31, 8'h10, 400);
        `CHK(d[4], 1'b0)
        u_host.rd_reg(8'h32, d);
        `CHK(d, 8'h20)
        rssi = 8'h50;
        u_host.wr_reg(8'h31, 8'h10);
        repeat (50) step;
        u_host.wr_reg(8'h31, 8'h00);
        u_host.rd_reg(8'h31, d);
        `CHK(d, 8'h00)
        u_host.rd_reg(8'h32, d);
        `CHK(d, 8'h20)
        u_host.wr_reg(8'h31, 8'h10);
        repeat (50) step;
        radio.state_chg = 1'b1;
        step;
        radio.state_chg = 1'b0;
        u_host.rd_reg(8'h31, d);
        `CHK(d, 8'h00)
    endtask
    task automatic t_cca;
        logic [7:0] rs [5] = '{8'h34, 8'h30, 8'h34, 8'h34, 8'h30};
        logic [7:0] ex [5] = '{8'h8C, 8'h0C, 8'h0C, 8'h0C, 8'h8C};
        logic [7:0] mn [5] = '{8'h34, 8'h30, 8'h30, 8'h34, 8'h30};
        for (int k = 0; k < 5; k++) begin
            rssi = rs[k];
            cca_mode = (k < 2) ? 2'h1 : 2'(k);
            cca_len = 2'(k == 3);
            radio.carrier_sense = (k == 4);
            n = n_done;
            u_host.wr_reg(8'h2F, 8'h4C);
            repeat (4) step;
            `CHK(rx_ctl.rx_gate, 1'b1)
            wait_clr(8'h2F, 8'h40, 100);
            repeat (3) step;
            u_host.rd_reg(8'h2F, d);
            `CHK(d, ex[k])
            `CHK(n_done - n, 1)
            u_host.rd_reg(8'h32, d);
            `CHK(d, mn[k])
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        trx_mode = 2'h0;
        cca_mode = 2'h1;
        cca_len = 2'h0;
        rssi = 8'h00;
        radio = '0;
        err_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset;
        t_access;
        t_rxctl;
        t_security;
        t_sampling;
        t_scan;
        t_cca;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up;
    end
endmodule
